// ---- dv/blc_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "blc_consts.svh"
module blc_host_model (
   input  wire logic        pclk,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [31:0] paddr,
   output var  logic [31:0] pwdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [32:0] r);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
      // A released bus shows no stale value.
      paddr <= ~a;
      pwdata <= ~d;
      if (n == 20) blc_top_tb.hang();
   endtask
   task automatic cred(input logic [255:0] c);
      logic [32:0] r;
      for (int i = 0; i < 8; i++) xfer(1'b1, `BLC_A_CRED + 32'(4 * i), c[32*i+:32], r);
   endtask
   task automatic cmd(input logic [7:0] op, input logic [7:0] m, input logic [4:0] b);
      logic [32:0] r;
      xfer(1'b1, `BLC_A_CMD, {11'h0, b, m, op}, r);
   endtask
endmodule
`default_nettype wire

// ---- dv/blc_top_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module blc_top_properties (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        med_valid,
   input wire logic        med_write,
   input wire logic [31:0] med_out_data,
   input wire logic        med_out_valid,
   input wire logic        med_out_write,
   input wire logic        med_refused
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_setup: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   a_unmapped_err: assert property (psel && penable && paddr >= 32'ha0 |-> pslverr)
      else $error("unmapped not flagged");
   a_mapped_ok: assert property (psel && penable && (paddr <= 32'h18 && paddr[1:0] == 2'h0 ||
      paddr[31:6] == 26'h1 || paddr[31:5] == 27'h4) |-> !pslverr)
      else $error("mapped flagged");
   // Supplied credentials must never come back out of the buffer.
   a_cred_hidden: assert property (psel && penable && !pwrite && paddr[31:6] == 26'h1
      |-> prdata == 32'h0)
      else $error("credential visible");
   a_read_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata outside read");
   a_media_echo: assert property (med_valid |=> med_out_valid && med_out_write == $past(med_write))
      else $error("media word lost");
   a_media_quiet: assert property (!med_valid |=> !med_out_valid)
      else $error("spurious media word");
   a_refused_blank: assert property (med_refused |-> med_out_valid && med_out_data == 32'h0)
      else $error("refused word carries data");
endmodule
bind blc_top blc_top_properties u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .med_valid(med_valid), .med_write(med_write),
   .med_out_data(med_out_data), .med_out_valid(med_out_valid),
   .med_out_write(med_out_write), .med_refused(med_refused));
`default_nettype wire

// ---- dv/blc_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "blc_consts.svh"
module blc_top_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, power_loss_event, noise_in;
   logic med_valid, med_write, med_out_valid, med_out_write, med_refused, fw, acc;
   logic [31:0] paddr, pwdata, prdata, med_lba, med_data, med_out_data, c, d;
   logic [4:0] med_band;
   logic [32:0] r;
   logic [32:0] rd_q[$];
   logic [38:0] med_q[$];
   int mismatches = 0;
   int tests_run = 0;
   blc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .power_loss_event(power_loss_event), .noise_in(noise_in),
      .med_valid(med_valid), .med_write(med_write), .med_lba(med_lba), .med_data(med_data),
      .med_out_valid(med_out_valid), .med_out_write(med_out_write),
      .med_out_data(med_out_data), .med_refused(med_refused), .med_band(med_band));
   blc_host_model h (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) noise_in <= 1'($urandom);
   task automatic chk(input logic [38:0] e, input logic [38:0] g);
      tests_run++;
      if (e !== g) begin
         mismatches++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   // Results are paired with the oldest note as they appear.
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         if (rd_q.size() > 0) chk({6'h0, rd_q.pop_front()}, {6'h0, pslverr, prdata});
         else chk(39'h0, 39'h1);
      end
      if (med_out_valid) begin
         if (med_q.size() > 0) chk(med_q[0], {med_q[0][38], med_refused, med_band,
            med_q[0][38] ? med_out_data : med_q[0][31:0]});
         if (med_q.size() > 0) void'(med_q.pop_front());
         else chk(39'h0, 39'h1);
      end
   end
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic err);
      rd_q.push_back({err, e});
      h.xfer(1'b0, a, 32'h0, r);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      h.xfer(1'b1, a, v, r);
   endtask
   task automatic st(input logic [3:0] e);
      rd(`BLC_A_STATUS, {21'h0, 1'b1, acc, fw, e, 2'b0, 1'b1, e == 4'h0}, 1'b0);
   endtask
   task automatic med(input logic w, input logic [31:0] a, input logic [31:0] v,
                      input logic [38:0] e, output logic [31:0] o);
      @(posedge pclk);
      med_valid <= 1'b1;
      med_write <= w;
      med_lba <= a;
      med_data <= v;
      med_q.push_back(e);
      @(posedge pclk);
      med_valid <= 1'b0;
      med_data <= ~v;
      @(posedge pclk);
      o = med_out_data;
   endtask
   task automatic sec(input blc_pkg::blc_method_t m, input logic [4:0] b);
      h.cmd(`BLC_OP_SEC_OUT, m, b);
   endtask
   task automatic hang();
      mismatches++;
      tally_and_finish();
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      presetn = 1'b0;
      {power_loss_event, med_valid, med_write, med_lba, med_data} = '0;
      fw = 1'b1;
      acc = 1'b0;
      void'($urandom(32'h633a));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(`BLC_A_STATUS, 32'h0000_0500, 1'b0);
      rd(`BLC_A_ALLOC, 32'h0, 1'b0);
      rd(32'h0000_00a0, 32'h0, 1'b1);
      h.cmd(`BLC_OP_SEC_IN, blc_pkg::M_READ_DEF, 5'h0);
      rd(`BLC_A_RESP, 32'(`BLC_FACT_CRED), 1'b0);
      $display("factory state done");
      h.cred({8{$urandom()}});
      sec(blc_pkg::M_FW_DIS, 5'h0);
      st(4'h2);
      h.cred(`BLC_FACT_CRED);
      rd(`BLC_A_CRED, 32'h0, 1'b0);
      sec(blc_pkg::M_FW_DIS, 5'h0);
      fw = 1'b0;
      st(4'h0);
      sec(blc_pkg::M_FW_EN, 5'h0);
      fw = 1'b1;
      st(4'h0);
      $display("credentials done");
      wr(`BLC_A_ARG0, 32'd100);
      wr(`BLC_A_ARG1, 32'd10);
      sec(blc_pkg::M_ALLOC, 5'h2);
      st(4'h4);
      sec(blc_pkg::M_BAND_EN, 5'h2);
      st(4'h0);
      sec(blc_pkg::M_ALLOC, 5'h1);
      st(4'h0);
      wr(`BLC_A_ARG0, 32'd105);
      wr(`BLC_A_ARG1, 32'd5);
      sec(blc_pkg::M_ALLOC, 5'h2);
      st(4'h5);
      wr(`BLC_A_ARG0, 32'd110);
      sec(blc_pkg::M_ALLOC, 5'h2);
      st(4'h0);
      rd(`BLC_A_ALLOC, 32'h6, 1'b0);
      med(1'b1, 32'd99, $urandom, {2'b00, 5'd0, 32'h0}, c);
      med(1'b1, 32'd100, $urandom, {2'b00, 5'd1, 32'h0}, c);
      med(1'b1, 32'd109, $urandom, {2'b00, 5'd1, 32'h0}, c);
      med(1'b1, 32'd115, $urandom, {2'b00, 5'd0, 32'h0}, c);
      d = $urandom;
      med(1'b1, 32'd112, d, {2'b00, 5'd2, 32'h0}, c);
      chk(39'h1, {38'h0, c !== d});
      med(1'b0, 32'd112, c, {2'b10, 5'd2, d}, r[31:0]);
      sec(blc_pkg::M_REKEY, 5'h2);
      st(4'h0);
      med(1'b0, 32'd112, c, {2'b00, 5'd2, 32'h0}, r[31:0]);
      chk(39'h0, {38'h0, r[31:0] === d});
      med(1'b1, 32'd112, d, {2'b00, 5'd2, 32'h0}, c);
      $display("bands done");
      wr(`BLC_A_ARG0, 32'h7);
      sec(blc_pkg::M_LOCK_CFG, 5'h1);
      wr(`BLC_A_ARG0, 32'h3);
      sec(blc_pkg::M_LOCK_CFG, 5'h2);
      @(posedge pclk);
      power_loss_event <= 1'b1;
      repeat (5) @(posedge pclk);
      power_loss_event <= 1'b0;
      rd(`BLC_A_LOCKED, 32'h2, 1'b0);
      med(1'b0, 32'd105, $urandom, {2'b11, 5'd1, 32'h0}, r[31:0]);
      med(1'b1, 32'd113, $urandom, {2'b00, 5'd2, 32'h0}, r[31:0]);
      sec(blc_pkg::M_UNLOCK, 5'h1);
      st(4'h0);
      rd(`BLC_A_LOCKED, 32'h0, 1'b0);
      $display("locking done");
      wr(`BLC_A_ARG0, 32'h3);
      sec(blc_pkg::M_FW_IMAGE, 5'h0);
      st(4'h8);
      wr(`BLC_A_ARG0, 32'h7);
      sec(blc_pkg::M_FW_IMAGE, 5'h0);
      acc = 1'b1;
      st(4'h0);
      h.cmd(8'h12, 8'h00, 5'h0);
      st(4'h1);
      h.cmd(`BLC_OP_SANIT, `BLC_SA_CRYPTO, 5'h0);
      st(4'h0);
      med(1'b0, 32'd112, c, {2'b00, 5'd2, 32'h0}, r[31:0]);
      chk(39'h0, {38'h0, r[31:0] === d});
      $display("erase done");
      sec(blc_pkg::M_REVERT, 5'h0);
      st(4'h2);
      h.cred(`BLC_LABEL_CRED);
      sec(blc_pkg::M_REVERT, 5'h0);
      rd(`BLC_A_ALLOC, 32'h0, 1'b0);
      $display("revert done");
      repeat (3) @(posedge pclk);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ---- src/blc_consts.svh ----
// Operation
// - Every media write is enciphered and every read deciphered inline, with no bypass.
// - Band keys are made internally, never shown to the host, stored wrapped.
// - Each of up to 32 bands has its own key, chosen per access.
// - Security commands with a credential lacking authority are rejected.
// - Firmware download enabling needs owner or factory default credential.
// - Media locking and erase need erase authority or that band's credential; the sanitize crypto erase checks no credential.
// - Owner, erase and band credentials start equal to the readable factory default credential.
// - A hardware random source makes keys and returns random words on request.
// - Power loss locks a band only with trigger, read allow and write allow set.
// - Reads and writes to a locked band are refused until unlocked.
// - Firmware download starts unlocked.
// - Initially only band 0 exists, covering every logical block.
// - Host allocates band 1 by start and count, taken from band 0.
// - Bands 2 to 31 need enabling under erase authority before allocation.
// - Overlapping band ranges are rejected; adjacent ranges are allowed.
// - Rekeying a band overwrites its key and keeps no earlier key.
// - Firmware images need variant, signature and compatibility all good.
// - Security payloads use opcodes b5h out and a2h in.
// - Sanitize 48h service action 3 replaces the media key with a fresh one.
// - Factory revert erases bands and restores providers, needs label revert credential.
`ifndef BLC_CONSTS_SVH
`define BLC_CONSTS_SVH

`define BLC_A_CMD      32'h0000_0000
`define BLC_A_ARG0     32'h0000_0004
`define BLC_A_ARG1     32'h0000_0008
`define BLC_A_STATUS   32'h0000_000c
`define BLC_A_LOCKED   32'h0000_0010
`define BLC_A_ALLOC    32'h0000_0014
`define BLC_A_ENABLED  32'h0000_0018
`define BLC_A_CRED     32'h0000_0040
`define BLC_M_CRED     32'hffff_ffc0
`define BLC_A_RESP     32'h0000_0080
`define BLC_M_RESP     32'hffff_ffe0

`define BLC_OP_SEC_OUT 8'hb5
`define BLC_OP_SEC_IN  8'ha2
`define BLC_OP_SANIT   8'h48
`define BLC_SA_CRYPTO  8'h03

`define BLC_LBA_MAX    32'hffff_ffff
`define BLC_FIRST_EN   5'h02
`define BLC_FACT_CRED  256'h5a17_c3e0_9b42_6d81_f0a5_3c96_e7d2_1b48_84ce_2f71_a039_6b5d_c812_4ef7_905a_d36b
`define BLC_LABEL_CRED 256'h3e91_7ac4_05d8_b26f_c1e3_9a57_248b_f60d_7d2c_e1a9_5b04_83f6_a7e0_16c9_d52b_4f38
`define BLC_RNG_SEED   256'h0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0001

`define BLC_F_LOCK_PWR 0
`define BLC_F_RD_ALLOW 1
`define BLC_F_WR_ALLOW 2
`define BLC_F_IMG_VAR  0
`define BLC_F_IMG_SIG  1
`define BLC_F_IMG_CMP  2

`define BLC_S_OK       0
`define BLC_S_DONE     1
`define BLC_S_FW_EN    8
`define BLC_S_FW_ACC   9
`define BLC_S_KEYS     10

`endif

// ---- src/blc_pkg.sv ----
`default_nettype none
package blc_pkg;

   typedef enum logic [7:0] {
      M_SET_OWNER = 8'h01,
      M_SET_ERASE = 8'h02,
      M_SET_BAND  = 8'h03,
      M_FW_EN     = 8'h04,
      M_FW_DIS    = 8'h05,
      M_BAND_EN   = 8'h06,
      M_ALLOC     = 8'h07,
      M_UNLOCK    = 8'h08,
      M_LOCK_CFG  = 8'h09,
      M_REKEY     = 8'h0a,
      M_REVERT    = 8'h0b,
      M_FW_IMAGE  = 8'h0c,
      M_READ_DEF  = 8'h10,
      M_READ_RNG  = 8'h11
   } blc_method_t;

   typedef enum logic [3:0] {
      E_NONE    = 4'h0,
      E_OPCODE  = 4'h1,
      E_AUTH    = 4'h2,
      E_RANGE   = 4'h3,
      E_NOTEN   = 4'h4,
      E_OVERLAP = 4'h5,
      E_METHOD  = 4'h6,
      E_KEYS    = 4'h7,
      E_IMAGE   = 4'h8
   } blc_err_t;

endpackage
`default_nettype wire

// ---- src/blc_top.sv ----
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "blc_consts.svh"

module blc_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        power_loss_event,
   input  wire logic        noise_in,
   input  wire logic        med_valid,
   input  wire logic        med_write,
   input  wire logic [31:0] med_lba,
   input  wire logic [31:0] med_data,
   output logic             med_out_valid,
   output logic             med_out_write,
   output logic      [31:0] med_out_data,
   output logic             med_refused,
   output logic      [4:0]  med_band
);

   function automatic logic overlaps(input logic [31:0] s1, input logic [31:0] l1,
                                     input logic [31:0] s2, input logic [31:0] l2);
      overlaps = !(l1 < s2 || s1 > l2);
   endfunction

   function automatic logic [255:0] rot(input logic [255:0] v, input logic [4:0] n);
      logic [511:0] d;
      d   = {v, v} << {n, 3'h0};
      rot = d[511:256];
   endfunction

   logic [255:0] owner_cred;
   logic [255:0] erase_cred;
   logic [255:0] band_cred [32];
   logic [255:0] key_store [32];
   logic [255:0] wrap_key;
   logic [255:0] rng;
   logic [31:0]  cbuf [16];
   logic [31:0]  resp [8];
   logic [31:0]  band_start [32];
   logic [31:0]  band_last [32];
   logic [31:0]  band_alloc;
   logic [31:0]  band_enabled;
   logic [31:0]  band_locked;
   logic [31:0]  lock_pwr;
   logic [31:0]  rd_allow;
   logic [31:0]  wr_allow;
   logic [31:0]  arg0;
   logic [31:0]  arg1;
   logic [31:0]  last_cmd;
   logic         fw_dl_en;
   logic         fw_accept;
   logic         keys_ready;
   logic         st_ok;
   logic         st_done;
   logic [3:0]   st_err;
   logic         pl_s1;
   logic         pl_s2;
   logic         pl_s3;
   logic         nz_s1;
   logic         nz_s2;

   // Bus decode.
   wire          setup    = psel & ~penable;
   wire          wr_en    = psel & penable & pready & pwrite;
   wire          cred_sel = (paddr & `BLC_M_CRED) == `BLC_A_CRED;
   wire          resp_sel = (paddr & `BLC_M_RESP) == `BLC_A_RESP;
   wire          cmd_go   = wr_en && paddr == `BLC_A_CMD;
   wire [7:0]    op       = pwdata[7:0];
   wire [7:0]    meth     = pwdata[15:8];
   wire [4:0]    cb       = pwdata[20:16];
   logic         mapped;
   logic [31:0]  rd_val;

   // Credential buffers: low half is presented authority, high half a new value.
   wire [255:0]  supplied;
   wire [255:0]  new_val;
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_cred
         assign supplied[g*32 +: 32] = cbuf[g];
         assign new_val[g*32 +: 32]  = cbuf[g+8];
      end
   endgenerate

   wire is_owner = supplied == owner_cred;
   wire [255:0] fact_cred = `BLC_FACT_CRED;
   wire is_def   = supplied == `BLC_FACT_CRED;
   wire is_erase = supplied == erase_cred;
   wire is_band  = supplied == band_cred[cb];
   wire is_label = supplied == `BLC_LABEL_CRED;
   wire admin_ok = is_owner | is_def;
   wire lock_ok  = is_erase | is_band;

   // Allocation range checks.
   wire [32:0]   last_ext = {1'b0, arg0} + {1'b0, arg1} - 33'h1;
   wire [31:0]   new_last = last_ext[31:0];
   wire          bad_rng  = arg1 == 32'h0 || last_ext[32] || new_last > `BLC_LBA_MAX;
   wire [31:0]   ovl;
   wire [31:0]   hit;
   generate
      for (g = 0; g < 32; g++) begin : g_band
         if (g == 0) begin : g_zero
            assign ovl[g] = 1'b0;
            assign hit[g] = 1'b0;
         end else begin : g_more
            // Adjacent ranges pass since the test is on inclusive ends.
            assign ovl[g] = band_alloc[g] && cb != 5'(g) &&
                            overlaps(arg0, new_last, band_start[g], band_last[g]);
            assign hit[g] = band_alloc[g] &&
                            overlaps(med_lba, med_lba, band_start[g], band_last[g]);
         end
      end
   endgenerate

   logic [4:0] sel;
   always_comb begin
      sel = 5'h0;
      for (int i = 1; i < 32; i++) begin
         if (hit[i]) begin
            sel = 5'(i);
         end
      end
   end

   // Command validation.
   blc_pkg::blc_err_t cmd_err;
   always_comb begin
      cmd_err = blc_pkg::E_NONE;
      if (!keys_ready) begin
         cmd_err = blc_pkg::E_KEYS;
      end else if (op == `BLC_OP_SANIT) begin
         if (meth != `BLC_SA_CRYPTO) cmd_err = blc_pkg::E_METHOD;
      end else if (op == `BLC_OP_SEC_IN) begin
         if (meth != blc_pkg::M_READ_DEF && meth != blc_pkg::M_READ_RNG) begin
            cmd_err = blc_pkg::E_METHOD;
         end
      end else if (op == `BLC_OP_SEC_OUT) begin
         case (meth)
            blc_pkg::M_SET_OWNER, blc_pkg::M_FW_EN, blc_pkg::M_FW_DIS: begin
               if (!admin_ok) cmd_err = blc_pkg::E_AUTH;
            end
            blc_pkg::M_SET_ERASE: begin
               if (!is_erase) cmd_err = blc_pkg::E_AUTH;
            end
            blc_pkg::M_BAND_EN: begin
               if (!is_erase) cmd_err = blc_pkg::E_AUTH;
               else if (cb < `BLC_FIRST_EN) cmd_err = blc_pkg::E_RANGE;
            end
            blc_pkg::M_SET_BAND, blc_pkg::M_UNLOCK, blc_pkg::M_LOCK_CFG,
            blc_pkg::M_REKEY: begin
               if (!lock_ok) cmd_err = blc_pkg::E_AUTH;
            end
            blc_pkg::M_ALLOC: begin
               if (!lock_ok) cmd_err = blc_pkg::E_AUTH;
               else if (cb == 5'h0) cmd_err = blc_pkg::E_RANGE;
               else if (cb >= `BLC_FIRST_EN && !band_enabled[cb]) cmd_err = blc_pkg::E_NOTEN;
               else if (bad_rng) cmd_err = blc_pkg::E_RANGE;
               else if (|ovl) cmd_err = blc_pkg::E_OVERLAP;
            end
            blc_pkg::M_REVERT: begin
               if (!is_label) cmd_err = blc_pkg::E_AUTH;
            end
            blc_pkg::M_FW_IMAGE: begin
               if (!fw_dl_en) cmd_err = blc_pkg::E_AUTH;
               else if (!(arg0[`BLC_F_IMG_VAR] && arg0[`BLC_F_IMG_SIG] &&
                          arg0[`BLC_F_IMG_CMP])) cmd_err = blc_pkg::E_IMAGE;
            end
            default: cmd_err = blc_pkg::E_METHOD;
         endcase
      end else begin
         cmd_err = blc_pkg::E_OPCODE;
      end
   end

   wire pass      = cmd_go && cmd_err == blc_pkg::E_NONE;
   wire sec_out   = pass && op == `BLC_OP_SEC_OUT;
   wire do_revert = sec_out && meth == blc_pkg::M_REVERT;
   wire do_sanit  = pass && op == `BLC_OP_SANIT;
   wire do_all    = !keys_ready || do_sanit || do_revert;
   wire do_rekey  = sec_out && meth == blc_pkg::M_REKEY;
   wire do_alloc  = sec_out && meth == blc_pkg::M_ALLOC;
   wire do_unlock = sec_out && meth == blc_pkg::M_UNLOCK;
   wire do_lcfg   = sec_out && meth == blc_pkg::M_LOCK_CFG;
   wire pl_pulse  = pl_s2 & ~pl_s3;
   // The wrap key moves only when every key is regenerated, so stored keys stay consistent.
   wire [255:0] next_wrap = do_all ? {rng[127:0], rng[255:128]} : wrap_key;

   // Synchronisers and the random source.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pl_s1 <= 1'b0;
         pl_s2 <= 1'b0;
         pl_s3 <= 1'b0;
         nz_s1 <= 1'b0;
         nz_s2 <= 1'b0;
         rng   <= `BLC_RNG_SEED;
      end else begin
         pl_s1 <= power_loss_event;
         pl_s2 <= pl_s1;
         pl_s3 <= pl_s2;
         nz_s1 <= noise_in;
         nz_s2 <= nz_s1;
         rng   <= {rng[254:0], rng[255] ^ rng[253] ^ rng[250] ^ rng[245] ^ nz_s2};
      end
   end

   // Keys are held only XORed with the wrap key; the raw key exists only in the data path.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wrap_key   <= '0;
         keys_ready <= 1'b0;
         for (int i = 0; i < 32; i++) key_store[i] <= '0;
      end else begin
         wrap_key   <= next_wrap;
         keys_ready <= 1'b1;
         for (int i = 0; i < 32; i++) begin
            if (do_all || (do_rekey && cb == 5'(i))) begin
               key_store[i] <= rot(rng, 5'(i)) ^ next_wrap;
            end
         end
      end
   end

   // Credentials and firmware gate.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         owner_cred <= `BLC_FACT_CRED;
         erase_cred <= `BLC_FACT_CRED;
         for (int i = 0; i < 32; i++) band_cred[i] <= `BLC_FACT_CRED;
         fw_dl_en   <= 1'b1;
         fw_accept  <= 1'b0;
      end else if (do_revert) begin
         owner_cred <= `BLC_FACT_CRED;
         erase_cred <= `BLC_FACT_CRED;
         for (int i = 0; i < 32; i++) band_cred[i] <= `BLC_FACT_CRED;
         fw_dl_en   <= 1'b1;
         fw_accept  <= 1'b0;
      end else if (sec_out) begin
         if (meth == blc_pkg::M_SET_OWNER) owner_cred <= new_val;
         if (meth == blc_pkg::M_SET_ERASE) erase_cred <= new_val;
         if (meth == blc_pkg::M_SET_BAND) band_cred[cb] <= new_val;
         if (meth == blc_pkg::M_FW_EN) fw_dl_en <= 1'b1;
         if (meth == blc_pkg::M_FW_DIS) fw_dl_en <= 1'b0;
         if (meth == blc_pkg::M_FW_IMAGE) fw_accept <= 1'b1;
      end else if (cmd_go && meth == blc_pkg::M_FW_IMAGE) begin
         fw_accept <= 1'b0;
      end
   end

   // Band table; band 0 is implicit and covers every block outside the allocated bands.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         band_alloc   <= '0;
         band_enabled <= '0;
         lock_pwr     <= '0;
         rd_allow     <= '0;
         wr_allow     <= '0;
         for (int i = 0; i < 32; i++) begin
            band_start[i] <= '0;
            band_last[i]  <= '0;
         end
      end else if (do_revert) begin
         band_alloc   <= '0;
         band_enabled <= '0;
         lock_pwr     <= '0;
         rd_allow     <= '0;
         wr_allow     <= '0;
      end else begin
         if (sec_out && meth == blc_pkg::M_BAND_EN) band_enabled[cb] <= 1'b1;
         if (do_alloc) begin
            band_alloc[cb] <= 1'b1;
            band_start[cb] <= arg0;
            band_last[cb]  <= new_last;
         end
         if (do_lcfg) begin
            lock_pwr[cb] <= arg0[`BLC_F_LOCK_PWR];
            rd_allow[cb] <= arg0[`BLC_F_RD_ALLOW];
            wr_allow[cb] <= arg0[`BLC_F_WR_ALLOW];
         end
      end
   end

   // A power-loss lock arriving with an unlock or a revert wins over the clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         band_locked <= '0;
      end else begin
         for (int i = 0; i < 32; i++) begin
            if (pl_pulse && lock_pwr[i] && rd_allow[i] && wr_allow[i]) begin
               band_locked[i] <= 1'b1;
            end else if (do_revert || (do_unlock && cb == 5'(i))) begin
               band_locked[i] <= 1'b0;
            end
         end
      end
   end

   // Media path: one cycle, key of the owning band, no bypass.
   wire [255:0] raw_key = key_store[sel] ^ wrap_key;
   wire [31:0]  key_wd  = raw_key[{med_lba[2:0], 5'h0} +: 32];
   wire [31:0]  tweak   = key_wd ^ {med_lba[15:0], med_lba[31:16]};
   wire         refuse  = band_locked[sel] || !keys_ready;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         med_out_valid <= 1'b0;
         med_out_write <= 1'b0;
         med_out_data  <= '0;
         med_refused   <= 1'b0;
         med_band      <= '0;
      end else begin
         med_out_valid <= med_valid;
         med_out_write <= med_write;
         med_refused   <= med_valid && refuse;
         med_out_data  <= refuse ? 32'h0 : med_data ^ tweak;
         med_band      <= sel;
      end
   end

   // Register writes and command status.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arg0     <= '0;
         arg1     <= '0;
         last_cmd <= '0;
         st_ok    <= 1'b0;
         st_done  <= 1'b0;
         st_err   <= '0;
         for (int i = 0; i < 16; i++) cbuf[i] <= '0;
         for (int i = 0; i < 8; i++) resp[i] <= '0;
      end else begin
         if (wr_en && paddr == `BLC_A_ARG0) arg0 <= pwdata;
         if (wr_en && paddr == `BLC_A_ARG1) arg1 <= pwdata;
         if (wr_en && cred_sel) cbuf[paddr[5:2]] <= pwdata;
         if (cmd_go) begin
            last_cmd <= pwdata;
            st_done  <= 1'b1;
            st_ok    <= pass;
            st_err   <= cmd_err;
         end
         // The label revert credential and the keys never reach this buffer.
         if (pass && op == `BLC_OP_SEC_IN) begin
            for (int i = 0; i < 8; i++) begin
               resp[i] <= (meth == blc_pkg::M_READ_DEF) ? fact_cred[i*32 +: 32]
                                                          : rng[i*32 +: 32];
            end
         end
      end
   end

   // Read mux; credential buffer is write-only so secrets are not echoed.
   always_comb begin
      mapped = 1'b1;
      rd_val = 32'h0;
      if (paddr == `BLC_A_CMD) rd_val = last_cmd;
      else if (paddr == `BLC_A_ARG0) rd_val = arg0;
      else if (paddr == `BLC_A_ARG1) rd_val = arg1;
      else if (paddr == `BLC_A_STATUS) begin
         rd_val[`BLC_S_OK]     = st_ok;
         rd_val[`BLC_S_DONE]   = st_done;
         rd_val[7:4]           = st_err;
         rd_val[`BLC_S_FW_EN]  = fw_dl_en;
         rd_val[`BLC_S_FW_ACC] = fw_accept;
         rd_val[`BLC_S_KEYS]   = keys_ready;
      end
      else if (paddr == `BLC_A_LOCKED) rd_val = band_locked;
      else if (paddr == `BLC_A_ALLOC) rd_val = band_alloc;
      else if (paddr == `BLC_A_ENABLED) rd_val = band_enabled;
      else if (resp_sel) rd_val = resp[paddr[4:2]];
      else if (!cred_sel) mapped = 1'b0;
   end

   // Answer is prepared in the setup cycle so the access phase never waits.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         prdata  <= (setup && !pwrite) ? rd_val : 32'h0;
      end
   end

endmodule
`default_nettype wire
